// >>> verilog/pcr_regs.sv
// Function
// - Bits 7..4 of the third control register enable the four timer compares to set their flags.
// - Bit 2 of the third control register masks the security interrupt and resets to 1.
// - Bit 1 of the third control register masks the buffer error interrupt and resets to 1.
// - Bit 0 of the third control register masks the wake interrupt and resets to 0.
// - Bit 3 of the third control register is reserved and resets to 0.
// - The frame length register is read only, holds the last header length in 6..0, bit 7 zero.
// - Bit 7 of the fourth control register blocks every source from the interrupt output.
// - Bit 6 of the fourth control register lets a third timer match abort receive or assessment.
// - Bit 5 of the fourth control register makes the device coordinator of the first network.
// - Bits 4..3 of the fourth control register pick the channel assessment type, reset mode 1.
// - A rising timer load bit copies the first compare value into the event timer.
// - The timer load bit clears itself and always reads zero.
// - The promiscuous bit bypasses all filtering except the length check of 5 to 127.
// - Bit 0 of the fourth control register lets a low 16-bit secondary match set the second flag.
// - A masked source still sets its own status bit.
`timescale 1ns/10ps
`default_nettype none

module pcr_regs #(
  parameter int TICK_CYCLES = pcr_pkg::TICK_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [pcr_pkg::ADDR_W-1:0] addr_in,
  input wire logic [pcr_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output var logic [pcr_pkg::DATA_W-1:0] rd_data_out,
  input wire logic [pcr_pkg::TMR_W-1:0] compare_value_one_in,
  input wire logic [pcr_pkg::TMR_W-1:0] compare_value_two_in,
  input wire logic [pcr_pkg::TMR_W-1:0] compare_value_three_in,
  input wire logic [pcr_pkg::TMR_W-1:0] compare_value_four_in,
  input wire logic [pcr_pkg::SEC_W-1:0] secondary_compare_value_in,
  input wire logic security_irq_in,
  input wire logic buffer_error_irq_in,
  input wire logic wake_irq_in,
  input wire logic frame_len_valid_in,
  input wire logic [pcr_pkg::LEN_W-1:0] phy_header_length_in,
  output var logic irq_n_out,
  output var logic [pcr_pkg::TMR_W-1:0] event_timer_out,
  output var logic timer_three_abort_out,
  output var logic pan_coordinator_first_out,
  output var logic [1:0] channel_assess_type_out,
  output var logic promiscuous_out,
  output var logic frame_length_ok_out
);
  import pcr_pkg::*;

  // ----------------------------------------------------------------
  // Registers and wires
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ctrl3_r;
  logic [DATA_W-1:0] ctrl4_r;
  logic [NUM_FLAGS-1:0] irqmask_r;
  logic [LEN_W-1:0] rxlen_r;
  logic [NUM_FLAGS-1:0] status_w;
  logic [15:0] tick_cnt_r;
  logic tmr_upd_r;

  wire sel_ctrl3_w = (addr_in == OFF_CTRL3);
  wire sel_ctrl4_w = (addr_in == OFF_CTRL4);
  wire sel_rxlen_w = (addr_in == OFF_RXLEN);
  wire sel_status_w = (addr_in == OFF_STATUS);
  wire sel_irqmask_w = (addr_in == OFF_IRQMASK);
  wire tick_w = (tick_cnt_r == 16'(TICK_CYCLES - 1));

  wire load_w = wr_en_in && sel_ctrl4_w && wr_data_in[C4_TMR_LOAD];

  wire [NUM_FLAGS-1:0] clr_w = (wr_en_in && sel_status_w) ? wr_data_in[NUM_FLAGS-1:0] : '0;
  wire [TMR_W-1:0] cmp_vals_w [NUM_TMR];
  assign cmp_vals_w[0] = compare_value_one_in;
  assign cmp_vals_w[1] = compare_value_two_in;
  assign cmp_vals_w[2] = compare_value_three_in;
  assign cmp_vals_w[3] = compare_value_four_in;

  // ----------------------------------------------------------------
  // Compare matches
  // ----------------------------------------------------------------
  logic [NUM_TMR-1:0] raw_match_w;
  logic [NUM_TMR-1:0] tmr_set_w;
  genvar t;
  generate
    for (t = 0; t < NUM_TMR; t++) begin : g_cmp
      assign raw_match_w[t] = tmr_upd_r && (event_timer_out == cmp_vals_w[t]);
      assign tmr_set_w[t] = raw_match_w[t] && ctrl3_r[C3_CMPEN_LSB + t];
    end
  endgenerate

  wire sec_match_w = tmr_upd_r && ctrl4_r[C4_SEC_CMP_EN] &&
                     (event_timer_out[SEC_W-1:0] == secondary_compare_value_in);

  wire [NUM_FLAGS-1:0] set_w = {wake_irq_in, buffer_error_irq_in, security_irq_in,
                                tmr_set_w[3], tmr_set_w[2],
                                tmr_set_w[1] | sec_match_w, tmr_set_w[0]};

  wire [NUM_FLAGS-1:0] eff_mask_w = irqmask_r |
                                    ({NUM_FLAGS{ctrl3_r[C3_SEC_MSK]}} & (7'h1 << ST_SEC)) |
                                    ({NUM_FLAGS{ctrl3_r[C3_BUF_MSK]}} & (7'h1 << ST_BUF)) |
                                    ({NUM_FLAGS{ctrl3_r[C3_WAKE_IRQ_MASK]}} & (7'h1 << ST_WAKE));
  wire [NUM_FLAGS-1:0] pending_w = status_w & ~eff_mask_w;

  wire irq_req_w = (|pending_w) && !ctrl4_r[C4_GLB_MSK];

  wire len_ok_w = (phy_header_length_in >= FRM_LEN_MIN) && (phy_header_length_in <= FRM_LEN_MAX);

  wire [DATA_W-1:0] rd_mux_w = sel_ctrl3_w ? ctrl3_r :
                               sel_ctrl4_w ? ctrl4_r :
                               sel_rxlen_w ? {1'b0, rxlen_r} :
                               sel_status_w ? {1'b0, status_w} :
                               sel_irqmask_w ? {1'b0, irqmask_r} : 8'h00;

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  pcr_flag_bits #(
    .N(NUM_FLAGS)
  ) u_flags (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .set_in(set_w),
    .clr_in(clr_w),
    .status_out(status_w)
  );

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // reset values of masks
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl3_r <= C3_RESET;
    end else if (wr_en_in && sel_ctrl3_w) begin
      ctrl3_r <= wr_data_in & C3_WMASK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl4_r <= C4_RESET;
    end else if (wr_en_in && sel_ctrl4_w) begin
      ctrl4_r <= wr_data_in & C4_WMASK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irqmask_r <= IRQMASK_RESET;
    end else if (wr_en_in && sel_irqmask_w) begin
      irqmask_r <= wr_data_in[NUM_FLAGS-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rxlen_r <= '0;
      frame_length_ok_out <= 1'b0;
    end else if (frame_len_valid_in) begin
      rxlen_r <= phy_header_length_in;
      frame_length_ok_out <= len_ok_w;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= rd_en_in ? rd_mux_w : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Event timer
  // ----------------------------------------------------------------
  // The timer advances on a divided enable so that one clock domain serves all.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_w ? 16'h0000 : tick_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      event_timer_out <= '0;
      tmr_upd_r <= 1'b0;
    end else begin
      tmr_upd_r <= tick_w || load_w;
      if (load_w) begin
        event_timer_out <= compare_value_one_in;
      end else if (tick_w) begin
        event_timer_out <= event_timer_out + 24'h000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_n_out <= 1'b1;
      timer_three_abort_out <= 1'b0;
      pan_coordinator_first_out <= 1'b0;
      channel_assess_type_out <= CCA_MODE1;
      promiscuous_out <= 1'b0;
    end else begin
      irq_n_out <= !irq_req_w;
      timer_three_abort_out <= raw_match_w[ST_TIMER_THREE] && ctrl4_r[C4_ABORT_SEL];
      pan_coordinator_first_out <= ctrl4_r[C4_PAN_COORD];
      channel_assess_type_out <= ctrl4_r[C4_CCA_LSB+1:C4_CCA_LSB];
      promiscuous_out <= ctrl4_r[C4_PROMISC];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_cmp_gate;
    @(posedge clk_in) disable iff (!rst_n_in)
      raw_match_w[ST_TMR1] && !ctrl3_r[C3_CMPEN_LSB] && !status_w[ST_TMR1]
      |=> !status_w[ST_TMR1];
  endproperty
  a_cmp_gate: assert property (p_cmp_gate) else $error("disabled compare set flag");

  property p_sec_irq;
    @(posedge clk_in) disable iff (!rst_n_in)
      status_w[ST_SEC] && !ctrl3_r[C3_SEC_MSK] && !irqmask_r[ST_SEC] && !ctrl4_r[C4_GLB_MSK]
      |=> !irq_n_out;
  endproperty
  a_sec_irq: assert property (p_sec_irq) else $error("unmasked security flag no irq");

  property p_buf_mask;
    @(posedge clk_in) disable iff (!rst_n_in)
      ctrl3_r[C3_BUF_MSK] && (status_w == (7'h1 << ST_BUF)) |=> irq_n_out;
  endproperty
  a_buf_mask: assert property (p_buf_mask) else $error("masked buffer error raised irq");

  property p_wake_wr;
    @(posedge clk_in) disable iff (!rst_n_in)
      wr_en_in && sel_ctrl3_w |=> ctrl3_r[C3_WAKE_IRQ_MASK] == $past(wr_data_in[C3_WAKE_IRQ_MASK]);
  endproperty
  a_wake_wr: assert property (p_wake_wr) else $error("wake mask did not take write");

  property p_rsvd3;
    @(posedge clk_in) disable iff (!rst_n_in)
      rd_en_in && sel_ctrl3_w |=> !rd_data_out[C3_RSVD];
  endproperty
  a_rsvd3: assert property (p_rsvd3) else $error("reserved bit read nonzero");

  property p_rxlen_rd;
    @(posedge clk_in) disable iff (!rst_n_in)
      rd_en_in && sel_rxlen_w |=> rd_data_out == {1'b0, $past(rxlen_r)};
  endproperty
  a_rxlen_rd: assert property (p_rxlen_rd) else $error("frame length readback wrong");

  property p_glb;
    @(posedge clk_in) disable iff (!rst_n_in)
      ctrl4_r[C4_GLB_MSK] || (pending_w == '0) |=> irq_n_out;
  endproperty
  a_glb: assert property (p_glb) else $error("irq asserted while masked");

  property p_abort;
    @(posedge clk_in) disable iff (!rst_n_in)
      raw_match_w[ST_TIMER_THREE] && ctrl4_r[C4_ABORT_SEL] |=> timer_three_abort_out;
  endproperty
  a_abort: assert property (p_abort) else $error("third timer abort missing");

  property p_load;
    @(posedge clk_in) disable iff (!rst_n_in)
      load_w |=> event_timer_out == $past(compare_value_one_in);
  endproperty
  a_load: assert property (p_load) else $error("timer load wrong value");

  property p_load_rd;
    @(posedge clk_in) disable iff (!rst_n_in)
      rd_en_in && sel_ctrl4_w |=> !rd_data_out[C4_TMR_LOAD];
  endproperty
  a_load_rd: assert property (p_load_rd) else $error("timer load bit read one");

  property p_len_chk;
    @(posedge clk_in) disable iff (!rst_n_in)
      frame_len_valid_in && (phy_header_length_in < FRM_LEN_MIN) |=> !frame_length_ok_out;
  endproperty
  a_len_chk: assert property (p_len_chk) else $error("short frame passed check");

  property p_sec_cmp;
    @(posedge clk_in) disable iff (!rst_n_in)
      sec_match_w |=> status_w[ST_TMR2];
  endproperty
  a_sec_cmp: assert property (p_sec_cmp) else $error("secondary match lost");

  property p_masked_set;
    @(posedge clk_in) disable iff (!rst_n_in)
      security_irq_in |=> status_w[ST_SEC];
  endproperty
  a_masked_set: assert property (p_masked_set) else $error("masked event not latched");

  property p_irq_on;
    @(posedge clk_in) disable iff (!rst_n_in)
      (pending_w != '0) && !ctrl4_r[C4_GLB_MSK] |=> !irq_n_out;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("unmasked flag gave no irq");

  property p_pan;
    @(posedge clk_in) disable iff (!rst_n_in)
      wr_en_in && sel_ctrl4_w
      |=> ##1 pan_coordinator_first_out == $past(wr_data_in[C4_PAN_COORD], 2);
  endproperty
  a_pan: assert property (p_pan) else $error("coordinator output not followed");

  property p_cca;
    @(posedge clk_in) disable iff (!rst_n_in)
      wr_en_in && sel_ctrl4_w
      |=> ##1 channel_assess_type_out == $past(wr_data_in[C4_CCA_LSB+1:C4_CCA_LSB], 2);
  endproperty
  a_cca: assert property (p_cca) else $error("assessment type not followed");

  property p_promisc;
    @(posedge clk_in) disable iff (!rst_n_in)
      wr_en_in && sel_ctrl4_w
      |=> ##1 promiscuous_out == $past(wr_data_in[C4_PROMISC], 2);
  endproperty
  a_promisc: assert property (p_promisc) else $error("promiscuous output not followed");

  property p_stat_rsvd;
    @(posedge clk_in) disable iff (!rst_n_in)
      rd_en_in && (sel_status_w || sel_irqmask_w) |=> !rd_data_out[DATA_W-1];
  endproperty
  a_stat_rsvd: assert property (p_stat_rsvd) else $error("status bit 7 read one");

endmodule

`default_nettype wire

// >>> shared/pcr_pkg.sv
package pcr_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFF_CTRL3 = 8'h05;
  localparam logic [ADDR_W-1:0] OFF_RXLEN = 8'h06;
  localparam logic [ADDR_W-1:0] OFF_CTRL4 = 8'h07;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQMASK = 8'h11;

  // ----------------------------------------------------------------
  // Third control register fields
  // ----------------------------------------------------------------
  localparam int C3_CMPEN_LSB = 4;
  localparam int C3_RSVD = 3;
  localparam int C3_SEC_MSK = 2;
  localparam int C3_BUF_MSK = 1;
  localparam int C3_WAKE_IRQ_MASK = 0;
  localparam logic [DATA_W-1:0] C3_RESET = 8'h06;
  localparam logic [DATA_W-1:0] C3_WMASK = 8'hf7;

  // ----------------------------------------------------------------
  // Fourth control register fields
  // ----------------------------------------------------------------
  localparam int C4_GLB_MSK = 7;
  localparam int C4_ABORT_SEL = 6;
  localparam int C4_PAN_COORD = 5;
  localparam int C4_CCA_LSB = 3;
  localparam int C4_TMR_LOAD = 2;
  localparam int C4_PROMISC = 1;
  localparam int C4_SEC_CMP_EN = 0;
  localparam logic [DATA_W-1:0] C4_RESET = 8'h08;
  localparam logic [DATA_W-1:0] C4_WMASK = 8'hfb;

  localparam logic [1:0] CCA_ENERGY = 2'h0;
  localparam logic [1:0] CCA_MODE1 = 2'h1;
  localparam logic [1:0] CCA_MODE2 = 2'h2;
  localparam logic [1:0] CCA_MODE3 = 2'h3;

  // ----------------------------------------------------------------
  // Interrupt status layout
  // ----------------------------------------------------------------
  localparam int NUM_TMR = 4;
  localparam int ST_TMR1 = 0;
  localparam int ST_TMR2 = 1;
  localparam int ST_TIMER_THREE = 2;
  localparam int ST_SEC = 4;
  localparam int ST_BUF = 5;
  localparam int ST_WAKE = 6;
  localparam int NUM_FLAGS = 7;
  localparam logic [NUM_FLAGS-1:0] IRQMASK_RESET = 7'h00;

  // ----------------------------------------------------------------
  // Frame length and event timer
  // ----------------------------------------------------------------
  localparam int LEN_W = 7;
  localparam logic [LEN_W-1:0] FRM_LEN_MIN = 7'h05;
  localparam logic [LEN_W-1:0] FRM_LEN_MAX = 7'h7f;
  localparam int TMR_W = 24;
  localparam int SEC_W = 16;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;

endpackage

// >>> verilog/pcr_flag_bits.sv
`timescale 1ns/10ps
`default_nettype none

module pcr_flag_bits #(
  parameter int N = 7
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [N-1:0] set_in,
  input wire logic [N-1:0] clr_in,
  output var logic [N-1:0] status_out
);

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  // A set in the clearing cycle wins, so no event is lost.
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          status_out[i] <= 1'b0;
        end else if (set_in[i]) begin
          status_out[i] <= 1'b1;
        end else if (clr_in[i]) begin
          status_out[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// >>> tb/pcr_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); \
  end \
end

module pcr_regs_tb_top;
  import pcr_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic [TMR_W-1:0] cv1 = 24'h000100;
  logic [TMR_W-1:0] cv2 = 24'h000104;
  logic [TMR_W-1:0] cv3 = 24'h000106;
  logic [TMR_W-1:0] cv4 = 24'h000102;
  logic [SEC_W-1:0] sec_cv = 16'h0108;
  logic [2:0] ev = 3'h0;
  logic len_vld = 1'b0;
  logic [LEN_W-1:0] len = 7'h00;
  logic irq_n;
  logic [TMR_W-1:0] timer;
  logic abort;
  logic pan;
  logic [1:0] cca;
  logic promisc;
  logic len_ok;
  int mismatches = 0;
  int cmp_count = 0;
  int abort_cnt = 0;
  logic [DATA_W-1:0] d;

  always #4 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    if (abort === 1'b1) begin
      abort_cnt++;
    end
  end

  pcr_regs #(.TICK_CYCLES(4)) dut_u (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .addr_in(addr),
    .wr_data_in(wdata),
    .wr_en_in(wr_en),
    .rd_en_in(rd_en),
    .rd_data_out(rd_data),
    .compare_value_one_in(cv1),
    .compare_value_two_in(cv2),
    .compare_value_three_in(cv3),
    .compare_value_four_in(cv4),
    .secondary_compare_value_in(sec_cv),
    .security_irq_in(ev[0]),
    .buffer_error_irq_in(ev[1]),
    .wake_irq_in(ev[2]),
    .frame_len_valid_in(len_vld),
    .phy_header_length_in(len),
    .irq_n_out(irq_n),
    .event_timer_out(timer),
    .timer_three_abort_out(abort),
    .pan_coordinator_first_out(pan),
    .channel_assess_type_out(cca),
    .promiscuous_out(promisc),
    .frame_length_ok_out(len_ok)
  );

  // ----------------------------------------------------------------
  // Bus and event helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk_in);
    wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_in);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
  endtask

  // One event pulse under the given masks, then a clear by writing ones.
  task automatic ev_case(input logic [2:0] s, input logic [7:0] c3, input logic [7:0] c4,
                         input logic [7:0] st, input logic irq);
    wr(OFF_CTRL3, c3);
    wr(OFF_CTRL4, c4);
    @(posedge clk_in);
    ev <= s;
    @(posedge clk_in);
    ev <= 3'h0;
    repeat (2) @(posedge clk_in);
    #1;
    `CHK("irq_n_out", irq, irq_n)
    rd(OFF_STATUS, d);
    `CHK("status", st, d)
    wr(OFF_STATUS, 8'h7f);
    repeat (2) @(posedge clk_in);
    #1;
    `CHK("irq_n_out cleared", 1'b1, irq_n)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `CHK("cca after reset", CCA_MODE1, cca)
    `CHK("irq after reset", 1'b1, irq_n)
    rd(OFF_CTRL3, d);
    `CHK("ctrl3 reset", 8'h06, d)
    @(posedge clk_in);
    #1;
    `CHK("read data after its cycle", 8'h00, rd_data)
    rd(OFF_CTRL4, d);
    `CHK("ctrl4 reset", 8'h08, d)
    rd(OFF_RXLEN, d);
    `CHK("rxlen reset", 8'h00, d)
  endtask

  task automatic t_fields();
    wr(OFF_CTRL3, 8'hff);
    rd(OFF_CTRL3, d);
    `CHK("ctrl3 readback", 8'hf7, d)
    wr(OFF_CTRL4, 8'hff);
    @(posedge clk_in);
    #1;
    `CHK("pan out", 1'b1, pan)
    `CHK("promisc out", 1'b1, promisc)
    rd(OFF_CTRL4, d);
    `CHK("ctrl4 readback", 8'hfb, d)
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CTRL4, {3'h0, 2'(i), 3'h0});
      @(posedge clk_in);
      #1;
      `CHK("cca out", 2'(i), cca)
    end
    wr(OFF_RXLEN, 8'hff);
    rd(OFF_RXLEN, d);
    `CHK("rxlen read only", 8'h00, d)
    rd(8'h20, d);
    `CHK("unmapped read", 8'h00, d)
    wr(OFF_CTRL3, 8'h06);
    wr(OFF_CTRL4, 8'h0a);
    // Timer flags raised above must not leak into the event cases.
    wr(OFF_STATUS, 8'h7f);
  endtask

  task automatic t_len(input logic [6:0] l, input logic ok);
    @(posedge clk_in);
    len <= l;
    len_vld <= 1'b1;
    @(posedge clk_in);
    len_vld <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    `CHK("length ok", ok, len_ok)
    rd(OFF_RXLEN, d);
    `CHK("rxlen", {1'b0, l}, d)
  endtask

  // Timer load starts a run whose compare results are read back later.
  task automatic t_timer(input logic [7:0] c3, input logic [7:0] c4, input int aborts);
    int a0;
    wr(OFF_CTRL3, c3);
    wr(OFF_STATUS, 8'h7f);
    a0 = abort_cnt;
    wr(OFF_CTRL4, c4);
    `CHK("timer loaded", 24'h000100, timer)
    rd(OFF_CTRL4, d);
    `CHK("load bit reads zero", c4 & 8'hfb, d)
    repeat (48) @(posedge clk_in);
    rd(OFF_STATUS, d);
    `CHK("timer flags", 8'h02, d)
    `CHK("abort pulses", aborts, abort_cnt - a0)
  endtask

  // The software mask keeps a source off the interrupt but not off its status bit.
  task automatic t_irqmask();
    wr(OFF_IRQMASK, 8'hff);
    rd(OFF_IRQMASK, d);
    `CHK("irqmask readback", 8'h7f, d)
    ev_case(3'h1, 8'h00, 8'h08, 8'h10, 1'b1);
    wr(OFF_IRQMASK, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task automatic results();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand cycles; this cuts a hang.
  initial begin
    repeat (5000) @(posedge clk_in);
    mismatches++;
    results();
  end

  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    t_reset();
    t_fields();
    t_len(7'h04, 1'b0);
    t_len(7'h05, 1'b1);
    t_len(7'h7f, 1'b1);
    ev_case(3'h1, 8'h00, 8'h08, 8'h10, 1'b0);
    ev_case(3'h1, 8'h04, 8'h08, 8'h10, 1'b1);
    ev_case(3'h2, 8'h02, 8'h08, 8'h20, 1'b1);
    ev_case(3'h2, 8'h00, 8'h08, 8'h20, 1'b0);
    ev_case(3'h4, 8'h01, 8'h08, 8'h40, 1'b1);
    ev_case(3'h4, 8'h00, 8'h88, 8'h40, 1'b1);
    ev_case(3'h4, 8'h00, 8'h08, 8'h40, 1'b0);
    t_irqmask();
    t_timer(8'h26, 8'h44, 1);
    t_timer(8'h06, 8'h05, 0);
    results();
  end
endmodule

`default_nettype wire
